// ---- src/ledtrm_top.v ----
// Trim register bank with two-wire serial slave port and OTP ROM model
`timescale 1ns/10ps
`include "ledtrm_regs.vh"
module ledtrm_top #(
	parameter [21:0] BURN_CYCLES = `LEDTRM_BURN_CYCLES,
	parameter [21:0] READ_CYCLES = `LEDTRM_READ_CYCLES
) (
	input wire clk_sys,
	input wire nrst,
	input wire sclIn,
	input wire sdaIn,
	output reg sdaOut,
	output reg sdaOe,
	output reg [5:0] switchTrimCode,
	output reg [3:0] linearTrimCode,
	output reg [6:0] switchChangeSteps,
	output reg [4:0] linearChangeSteps,
	output reg burnSupplyHigh,
	output reg romReadActive,
	output reg romProgrammed
);
	// ----------------------------------------
	// Serial engine states
	// ----------------------------------------
	localparam [3:0] ST_IDLE = 4'h0;
	localparam [3:0] ST_ADDR = 4'h1;
	localparam [3:0] ST_AACK = 4'h2;
	localparam [3:0] ST_ADRV = 4'h3;
	localparam [3:0] ST_WREG = 4'h4;
	localparam [3:0] ST_RACK = 4'h5;
	localparam [3:0] ST_RDRV = 4'h6;
	localparam [3:0] ST_WDATA = 4'h7;
	localparam [3:0] ST_DACK = 4'h8;
	localparam [3:0] ST_DDRV = 4'h9;
	localparam [3:0] ST_RDATA = 4'ha;
	localparam [3:0] ST_RMACK = 4'hb;

	wire sclS;
	wire sdaS;
	reg sclD;
	reg sdaD;
	reg [3:0] state;
	reg [2:0] bitCnt;
	reg [7:0] shiftReg;
	reg [7:0] rdShift;
	reg [7:0] regIndex;
	reg masterAck;
	reg wrStrobe;
	reg [7:0] wrData;
	reg [7:0] swReg;
	reg [7:0] linReg;
	reg [7:0] romCtl;
	reg [5:0] fuseSw;
	reg [3:0] fuseLin;
	reg fuseBurned;
	reg [21:0] burnCnt;
	reg [21:0] readCnt;
	reg [7:0] readValue;

	wire sclRise;
	wire sclFall;
	wire startCond;
	wire stopCond;
	wire wrRom;
	wire burnDone;

	// ----------------------------------------
	// Pin synchronisers and bus conditions
	// ----------------------------------------
	ledtrm_sync #(
		.RST_LEVEL(1'b1)
	) syncScl (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.asyncIn(sclIn),
		.syncOut(sclS)
	);

	ledtrm_sync #(
		.RST_LEVEL(1'b1)
	) syncSda (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.asyncIn(sdaIn),
		.syncOut(sdaS)
	);

	always @(posedge clk_sys) begin
		if (!nrst) begin
			sclD <= 1'b1;
			sdaD <= 1'b1;
		end else begin
			sclD <= sclS;
			sdaD <= sdaS;
		end
	end

	assign sclRise = sclS & ~sclD;
	assign sclFall = ~sclS & sclD;
	// SDA moving while SCL is high aborts whatever transfer was running
	assign startCond = sclS & sclD & sdaD & ~sdaS;
	assign stopCond = sclS & sclD & ~sdaD & sdaS;

	// ----------------------------------------
	// Read data selection
	// ----------------------------------------
	always @* begin
		readValue = 8'h00;
		case (regIndex)
			`LEDTRM_ADDR_SW: begin
				readValue = swReg; // RULE15
			end
			`LEDTRM_ADDR_LIN: begin
				readValue = linReg; // RULE15
			end
			`LEDTRM_ADDR_ROM: begin
				readValue = romCtl;
				readValue[`LEDTRM_BIT_BURNED] = romProgrammed; // RULE9
				readValue[`LEDTRM_BIT_RELOAD] = 1'b0; // RULE14
			end
			default: begin
				readValue = 8'h00;
			end
		endcase
	end

	// ----------------------------------------
	// Serial slave engine
	// ----------------------------------------
	always @(posedge clk_sys) begin
		if (!nrst) begin
			state <= ST_IDLE;
			bitCnt <= 3'h0;
			shiftReg <= 8'h00;
			rdShift <= 8'h00;
			regIndex <= 8'h00;
			masterAck <= 1'b0;
			wrStrobe <= 1'b0;
			wrData <= 8'h00;
			sdaOut <= 1'b0;
			sdaOe <= 1'b0;
		end else begin
			wrStrobe <= 1'b0;
			sdaOut <= 1'b0;
			if (startCond) begin
				state <= ST_ADDR;
				bitCnt <= 3'h0;
				sdaOe <= 1'b0;
			end else if (stopCond) begin
				state <= ST_IDLE;
				sdaOe <= 1'b0;
			end else begin
				case (state)
					ST_IDLE: begin
						sdaOe <= 1'b0;
					end
					ST_ADDR, ST_WREG, ST_WDATA: begin
						if (sclRise) begin
							shiftReg <= {shiftReg[6:0], sdaS};
							bitCnt <= bitCnt + 3'h1;
							if (bitCnt == 3'h7) begin
								state <= (state == ST_ADDR) ? ST_AACK :
									(state == ST_WREG) ? ST_RACK : ST_DACK;
							end
						end
					end
					ST_AACK: begin
						if (sclFall) begin
							if (shiftReg[7:1] == `LEDTRM_SLAVE_ADDR) begin // RULE11
								sdaOe <= 1'b1;
								masterAck <= shiftReg[0];
								state <= ST_ADRV;
							end else begin
								state <= ST_IDLE;
							end
						end
					end
					ST_ADRV: begin
						if (sclFall) begin
							bitCnt <= 3'h0;
							if (masterAck) begin
								rdShift <= {readValue[6:0], 1'b0}; // RULE15
								sdaOe <= ~readValue[7];
								state <= ST_RDATA;
							end else begin
								sdaOe <= 1'b0;
								state <= ST_WREG;
							end
						end
					end
					ST_RACK, ST_DACK: begin
						if (sclFall) begin
							sdaOe <= 1'b1;
							state <= (state == ST_RACK) ? ST_RDRV : ST_DDRV;
						end
					end
					ST_RDRV: begin
						if (sclFall) begin
							regIndex <= shiftReg; // RULE11
							sdaOe <= 1'b0;
							bitCnt <= 3'h0;
							state <= ST_WDATA;
						end
					end
					ST_DDRV: begin
						if (sclRise) begin
							wrStrobe <= 1'b1; // RULE12
							wrData <= shiftReg;
						end
						// Only one data byte per transfer; further bytes go unanswered
						if (sclFall) begin
							sdaOe <= 1'b0;
							state <= ST_IDLE;
						end
					end
					ST_RDATA: begin
						if (sclFall) begin
							bitCnt <= bitCnt + 3'h1;
							if (bitCnt == 3'h7) begin
								sdaOe <= 1'b0;
								state <= ST_RMACK;
							end else begin
								sdaOe <= ~rdShift[7];
								rdShift <= {rdShift[6:0], 1'b0};
							end
						end
					end
					ST_RMACK: begin
						if (sclRise) begin
							masterAck <= ~sdaS;
						end
						if (sclFall) begin
							if (masterAck) begin
								bitCnt <= 3'h0;
								rdShift <= {readValue[6:0], 1'b0};
								sdaOe <= ~readValue[7];
								state <= ST_RDATA;
							end else begin
								state <= ST_IDLE;
							end
						end
					end
					default: begin
						state <= ST_IDLE;
						sdaOe <= 1'b0;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// Register bank, burn and ROM read cycle
	// ----------------------------------------
	assign wrRom = wrStrobe && (regIndex == `LEDTRM_ADDR_ROM);
	// Burn only when the burn bit went back to 0 after the full hold time
	assign burnDone = wrRom && romCtl[`LEDTRM_BIT_BURN] && !wrData[`LEDTRM_BIT_BURN] &&
		(burnCnt >= BURN_CYCLES) && !fuseBurned; // RULE13

	always @(posedge clk_sys) begin
		if (!nrst) begin
			swReg <= `LEDTRM_RST_SW; // RULE1
			linReg <= `LEDTRM_RST_LIN; // RULE3
			romCtl <= `LEDTRM_RST_ROM; // RULE7
			romProgrammed <= 1'b0;
			romReadActive <= 1'b1; // RULE5
			readCnt <= 22'h000000;
			burnCnt <= 22'h000000;
			// Nrst stands for first power: the fuses start blank at nominal codes
			fuseSw <= 6'h1f;
			fuseLin <= 4'h7;
			fuseBurned <= 1'b0;
		end else begin
			if (wrStrobe && regIndex == `LEDTRM_ADDR_SW) begin
				swReg <= wrData; // RULE6
			end
			if (wrStrobe && regIndex == `LEDTRM_ADDR_LIN) begin
				linReg <= wrData; // RULE6
			end
			if (wrRom) begin
				// Flag and reload bits are not stored; reserved bits are kept
				romCtl <= {wrData[7:5], 1'b0, wrData[3:1], 1'b0}; // RULE8
				if (wrData[`LEDTRM_BIT_RELOAD]) begin
					romReadActive <= 1'b1; // RULE14
					readCnt <= 22'h000000;
				end
			end
			if (romCtl[`LEDTRM_BIT_BURN]) begin
				if (burnCnt < BURN_CYCLES) begin
					burnCnt <= burnCnt + 22'h000001;
				end
			end else begin
				burnCnt <= 22'h000000;
			end
			if (burnDone) begin
				fuseSw <= swReg[5:0]; // RULE6
				fuseLin <= linReg[3:0];
				fuseBurned <= 1'b1;
			end
			if (romReadActive && !(wrRom && wrData[`LEDTRM_BIT_RELOAD])) begin
				if (readCnt >= READ_CYCLES - 22'h000001) begin
					// The ROM load wins over a host write landing in the same cycle
					swReg <= {2'b00, fuseSw}; // RULE5
					linReg <= {4'h0, fuseLin}; // RULE5
					romProgrammed <= fuseBurned; // RULE10
					romReadActive <= 1'b0;
				end else begin
					readCnt <= readCnt + 22'h000001;
				end
			end
		end
	end

	// ----------------------------------------
	// Trim outputs
	// ----------------------------------------
	always @(posedge clk_sys) begin
		if (!nrst) begin
			switchTrimCode <= 6'h1f;
			linearTrimCode <= 4'h7;
			switchChangeSteps <= 7'h00;
			linearChangeSteps <= 5'h00;
			burnSupplyHigh <= 1'b0;
		end else begin
			switchTrimCode <= swReg[5:0];
			linearTrimCode <= linReg[3:0];
			switchChangeSteps <= `LEDTRM_SW_NOMINAL - {1'b0, swReg[5:0]}; // RULE2
			linearChangeSteps <= `LEDTRM_LIN_NOMINAL - {1'b0, linReg[3:0]}; // RULE4
			burnSupplyHigh <= romCtl[`LEDTRM_BIT_BURN];
		end
	end
endmodule

// ---- src/ledtrm_regs.vh ----
// Constants of the LED current trim register bank and its serial slave port
// Function
// RULE1 - The switching-string trim register sits at 0x01, code in bits 5:0, reset 0x1f.
// RULE2 - The switching-string current change is (31 - code) steps of 0.625 percent.
// RULE3 - The linear-string trim register sits at 0x02, code in bits 3:0, reset 0x07.
// RULE4 - The linear-string current change is (7 - code) steps of 3.125 percent.
// RULE5 - At power-up both trim registers are loaded from the OTP ROM contents.
// RULE6 - Trial codes may be written and are made permanent by the ROM write cycle.
// RULE7 - The ROM control and status register sits at 0xff, reset 0x08, flag bit 4, burn 2, reload 0.
// RULE8 - The host writes zeros into bits 7 to 5 of the ROM control register.
// RULE9 - The programmed flag reads 1 once the OTP ROM has been burned.
// RULE10 - The programmed flag changes only at a ROM read cycle, run at power-up or on reload.
// RULE11 - The port answers slave address 0x28; register index byte then data byte.
// RULE12 - A written value takes effect at the SCL rising edge of the final device acknowledge.
// RULE13 - The host holds the burn bit at 1 for at least 25 ms before clearing it.
// RULE14 - Writing 1 to the reload bit reloads both trims from ROM, and the bit reads as 0.
// RULE15 - A read is an index-only write followed by a read transfer returning the stored byte.
`ifndef LEDTRM_REGS_VH
`define LEDTRM_REGS_VH

// ----------------------------------------
// Bus address and register offsets
// ----------------------------------------
`define LEDTRM_SLAVE_ADDR 7'h28
`define LEDTRM_ADDR_SW 8'h01
`define LEDTRM_ADDR_LIN 8'h02
`define LEDTRM_ADDR_ROM 8'hff

// ----------------------------------------
// Reset values and fields
// ----------------------------------------
`define LEDTRM_RST_SW 8'h1f
`define LEDTRM_RST_LIN 8'h07
`define LEDTRM_RST_ROM 8'h08
`define LEDTRM_BIT_BURNED 4
`define LEDTRM_BIT_BURN 2
`define LEDTRM_BIT_RELOAD 0
`define LEDTRM_SW_NOMINAL 7'h1f
`define LEDTRM_LIN_NOMINAL 5'h07

// ----------------------------------------
// Timing
// ----------------------------------------
`define LEDTRM_CLK_MHZ 125
`define LEDTRM_BURN_MIN_MS 25
`define LEDTRM_ROM_READ_US 50
// Cycle counts at 125 MHz, sized to the 22-bit counters: 25 ms burn hold, 50 us ROM read
`define LEDTRM_BURN_CYCLES 22'd3125000
`define LEDTRM_READ_CYCLES 22'd6250

`endif

// ---- src/ledtrm_sync.v ----
// Two flip-flop synchroniser for one bus pin
`timescale 1ns/10ps
module ledtrm_sync #(
	parameter RST_LEVEL = 1'b1
) (
	input wire clk_sys,
	input wire nrst,
	input wire asyncIn,
	output reg syncOut
);
	reg stage1;

	// Pins idle high, so reset to the idle level to avoid a false start
	always @(posedge clk_sys) begin
		if (!nrst) begin
			stage1 <= RST_LEVEL;
			syncOut <= RST_LEVEL;
		end else begin
			stage1 <= asyncIn;
			syncOut <= stage1;
		end
	end
endmodule

// ---- testbench/ledtrm_top_properties.sv ----
// Concurrent checks on the trim register bank ports
`timescale 1ns/10ps
module ledtrm_top_properties #(
	parameter [21:0] BURN_CYCLES = 22'd20,
	parameter [21:0] READ_CYCLES = 22'd8
) (
	input logic clk_sys,
	input logic nrst,
	input logic sclIn,
	input logic sdaOut,
	input logic sdaOe,
	input logic [5:0] switchTrimCode,
	input logic [3:0] linearTrimCode,
	input logic [6:0] switchChangeSteps,
	input logic [4:0] linearChangeSteps,
	input logic romReadActive,
	input logic romProgrammed
);
	int readCnt;
	// Counter keeps the read cycle bound cheap for long parameter values
	always @(posedge clk_sys) begin
		if (!nrst || !romReadActive) begin
			readCnt <= 0;
		end else begin
			readCnt <= readCnt + 1;
		end
	end
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);
	sequence s_released;
		$rose(nrst);
	endsequence
	a_reset_vals: assert property (s_released |-> switchTrimCode == 6'h1f &&
		linearTrimCode == 4'h7 && !romProgrammed && romReadActive)
		else $error("trim outputs wrong after reset");
	a_sw_steps: assert property ($stable(switchTrimCode) |->
		switchChangeSteps == 7'h1f - {1'b0, switchTrimCode})
		else $error("switch steps wrong");
	a_lin_steps: assert property ($stable(linearTrimCode) |->
		linearChangeSteps == 5'h07 - {1'b0, linearTrimCode})
		else $error("linear steps wrong");
	a_sda_low: assert property (!sdaOut)
		else $error("data pin driven high");
	a_ack_scl: assert property ($changed(sdaOe) |-> !sclIn)
		else $error("data pin moved while clock high");
	a_flag_read: assert property ($changed(romProgrammed) |->
		$past(romReadActive) || $past(romReadActive, 2))
		else $error("flag moved outside a read cycle");
	a_read_len: assert property (readCnt <= READ_CYCLES + 3)
		else $error("read cycle too long");
	a_code_change: assert property ($changed(switchTrimCode) || $changed(linearTrimCode) |->
		sclIn || $past(romReadActive) || $past(romReadActive, 2) || $past(romReadActive, 3))
		else $error("trim changed outside commit or load");
endmodule
bind ledtrm_top ledtrm_top_properties #(.BURN_CYCLES(BURN_CYCLES), .READ_CYCLES(READ_CYCLES))
	u_props (.*);

// ---- testbench/ledtrm_host_model.sv ----
// Bus master model for the trim register bank serial port
`timescale 1ns/10ps
module ledtrm_host_model (
	input logic clk_sys,
	input logic sdaLine,
	output logic scl,
	output logic sdaLow,
	output logic [7:0] rdByte,
	output logic rdDone,
	output logic ackAll
);
	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
		rdByte = 8'h00;
		rdDone = 1'b0;
		ackAll = 1'b1;
	end
	// Quarter bit of six cycles keeps clock high well above the sync latency
	task automatic q;
		repeat (6) @(posedge clk_sys);
	endtask
	task automatic clk_bit(input logic b, output logic s);
		sdaLow <= !b;
		q();
		scl <= 1'b1;
		q();
		s = sdaLine;
		q();
		scl <= 1'b0;
		q();
	endtask
	task automatic start;
		sdaLow <= 1'b0;
		q();
		scl <= 1'b1;
		q();
		sdaLow <= 1'b1;
		q();
		scl <= 1'b0;
		q();
	endtask
	task automatic stop;
		sdaLow <= 1'b1;
		q();
		scl <= 1'b1;
		q();
		sdaLow <= 1'b0;
		q();
	endtask
	// Ninth bit is always released: device ack on writes, final nack on reads
	task automatic xfer(input logic [7:0] d, input logic isRd, output logic [7:0] r);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(d[i], s);
			r[i] = s;
		end
		clk_bit(1'b1, s);
		if (!isRd && s) begin
			ackAll = 1'b0;
		end
	endtask
	task automatic wr(input logic [6:0] dev, input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] r;
		ackAll = 1'b1;
		start();
		xfer({dev, 1'b0}, 1'b0, r);
		xfer(idx, 1'b0, r);
		xfer(d, 1'b0, r);
		stop();
	endtask
	task automatic rd(input logic [6:0] dev, input logic [7:0] idx);
		logic [7:0] r;
		ackAll = 1'b1;
		start();
		xfer({dev, 1'b0}, 1'b0, r);
		xfer(idx, 1'b0, r);
		start();
		xfer({dev, 1'b1}, 1'b0, r);
		xfer(8'hff, 1'b1, r);
		stop();
		rdByte <= r;
		rdDone <= 1'b1;
		@(posedge clk_sys);
		rdDone <= 1'b0;
	endtask
endmodule

// ---- testbench/tb_led_current_trim_otp_regs.sv ----
// Self-checking bench for the trim register bank
`timescale 1ns/10ps
`include "ledtrm_regs.vh"
module tb_led_current_trim_otp_regs;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	wire scl;
	wire sdaLow;
	wire sdaOut;
	wire sdaOe;
	wire [5:0] swCode;
	wire [3:0] linCode;
	wire [6:0] swSteps;
	wire [4:0] linSteps;
	wire burnHigh;
	wire readAct;
	wire burned;
	logic [7:0] rdByte;
	logic rdDone;
	logic ackAll;
	logic [7:0] expQ[$];
	logic [7:0] rnd = 8'h04;
	logic [7:0] sw;
	logic [7:0] lin;
	int bad_count = 0;
	int checks_done = 0;
	int cycles = 0;
	wire sdaLine = !(sdaOe | sdaLow);
	always #4 clk_sys = !clk_sys;
	ledtrm_top #(.BURN_CYCLES(22'd20), .READ_CYCLES(22'd8)) i_dut (.clk_sys(clk_sys),
		.nrst(nrst), .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
		.switchTrimCode(swCode), .linearTrimCode(linCode), .switchChangeSteps(swSteps),
		.linearChangeSteps(linSteps), .burnSupplyHigh(burnHigh), .romReadActive(readAct),
		.romProgrammed(burned));
	ledtrm_host_model i_host (.clk_sys(clk_sys), .sdaLine(sdaLine), .scl(scl),
		.sdaLow(sdaLow), .rdByte(rdByte), .rdDone(rdDone), .ackAll(ackAll));
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		i_host.wr(`LEDTRM_SLAVE_ADDR, idx, d);
	endtask
	task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
		expQ.push_back(exp);
		i_host.rd(`LEDTRM_SLAVE_ADDR, idx);
	endtask
	task automatic wait_read;
		for (int i = 0; i < 100 && readAct; i++) begin
			@(posedge clk_sys);
		end
	endtask
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles > 60000) begin
			bad_count++;
			finish_test();
		end
		if (rdDone) begin
			check("read data", rdByte, expQ.pop_front());
		end
	end
	initial begin
		repeat (3) @(posedge clk_sys);
		nrst <= 1'b1;
		@(posedge clk_sys);
		#1 check("read active", readAct, 8'h01);
		wait_read();
		check("switch code", swCode, 8'h1f);
		check("linear code", linCode, 8'h07);
		rd(`LEDTRM_ADDR_SW, `LEDTRM_RST_SW);
		rd(`LEDTRM_ADDR_LIN, `LEDTRM_RST_LIN);
		rd(`LEDTRM_ADDR_ROM, `LEDTRM_RST_ROM);
		$display("test reset values done");
		// Both code extremes first, then pseudo-random codes with reserved bits set
		for (int i = 0; i < 6; i++) begin
			rnd = lfsr(rnd);
			sw = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : rnd;
			lin = ~sw;
			wr(`LEDTRM_ADDR_SW, sw);
			wr(`LEDTRM_ADDR_LIN, lin);
			check("ack", ackAll, 8'h01);
			check("switch code", swCode, sw[5:0]);
			check("switch steps", swSteps, 7'(7'h1f - {1'b0, sw[5:0]}));
			check("linear steps", linSteps, 5'(5'h07 - {1'b0, lin[3:0]}));
			rd(`LEDTRM_ADDR_SW, sw);
			rd(`LEDTRM_ADDR_LIN, lin);
		end
		$display("test trim codes done");
		i_host.wr(7'h29, `LEDTRM_ADDR_SW, 8'h15);
		check("foreign ack", ackAll, 8'h00);
		wr(8'h10, 8'h5a);
		rd(8'h10, 8'h00);
		rd(`LEDTRM_ADDR_SW, sw);
		$display("test refusals done");
		wr(`LEDTRM_ADDR_SW, 8'h2a);
		wr(`LEDTRM_ADDR_LIN, 8'h0c);
		wr(`LEDTRM_ADDR_ROM, 8'h04);
		check("burn supply", burnHigh, 8'h01);
		repeat (30) @(posedge clk_sys);
		wr(`LEDTRM_ADDR_ROM, 8'h00);
		check("burn supply off", burnHigh, 8'h00);
		check("flag before read", burned, 8'h00);
		wr(`LEDTRM_ADDR_SW, 8'h05);
		wr(`LEDTRM_ADDR_ROM, 8'h01);
		wait_read();
		check("flag", burned, 8'h01);
		check("switch code", swCode, 8'h2a);
		check("linear code", linCode, 8'h0c);
		rd(`LEDTRM_ADDR_ROM, 8'h10);
		$display("test burn and reload done");
		finish_test();
	end
endmodule
